// [verilog/hpm_mux.sv]
`timescale 1ns/10ps
module hpm_mux
  import hpm_pkg::*;
(
  input  wire logic                            i_clock,
  input  wire logic                            i_rst,
  input  wire logic                            i_function_strap_pin,
  input  wire logic [hpm_pkg::DATA_WIDTH-1:0]  i_host_port_data_pins,
  output logic      [hpm_pkg::DATA_WIDTH-1:0]  o_host_port_data_pins,
  output logic      [hpm_pkg::DATA_WIDTH-1:0]  o_host_port_data_oe_n,
  input  wire logic                            i_hold_enable_wr,
  input  wire logic                            i_hold_enable_val,
  output logic                                 o_hold_enable,
  output logic                                 o_host_mode,
  input  wire logic                            i_gpio_dir_wr,
  input  wire logic [hpm_pkg::DATA_WIDTH-1:0]  i_gpio_dir,
  input  wire logic [hpm_pkg::DATA_WIDTH-1:0]  i_parallel_gpio_out,
  output logic      [hpm_pkg::DATA_WIDTH-1:0]  o_parallel_gpio_bits,
  input  wire logic                            i_host_address_strobe,
  input  wire logic                            i_host_strobe,
  input  wire logic                            i_host_read,
  input  wire logic [2*hpm_pkg::DATA_WIDTH-1:0] i_host_read_word,
  output logic      [2*hpm_pkg::DATA_WIDTH-1:0] o_host_word,
  output logic                                 o_host_word_valid,
  output logic      [2*hpm_pkg::DATA_WIDTH-1:0] o_host_address_register,
  output logic                                 o_host_address_valid
);
  import hpm_pkg::*;

  localparam int W = DATA_WIDTH;

  logic [W-1:0]   pins_s;
  logic           as_s;
  logic           strb_s;
  logic           rd_s;
  logic           strap_m;
  logic           strap_s;
  logic           sel_done;
  logic           host_fn;
  logic           hold_en;
  logic [W-1:0]   gpio_dir;
  logic [W-1:0]   gpio_in;
  logic [W-1:0]   pin_out;
  logic [W-1:0]   pin_oe_n;
  logic [W-1:0]   keep_level;
  logic [W-1:0]   next_pin_out;
  logic [W-1:0]   next_pin_oe_n;
  logic           strb_d;
  logic           as_d;
  logic           strb_rise;
  logic           as_rise;
  logic           pair_done;
  logic           addr_pend;
  hpm_phase_type  phase;
  logic [W-1:0]   first_byte;
  logic [2*W-1:0] word;
  logic           word_valid;
  logic [2*W-1:0] addr_reg;
  logic           addr_valid;

  // rising edge of a synchronised strobe
  function automatic logic rise_of(input logic now_val,
                                   input logic was_val);
    return now_val & ~was_val;
  endfunction : rise_of

  // byte of a read word for the current phase, high byte first
  function automatic logic [W-1:0] byte_of(input logic [2*W-1:0] w,
                                           input hpm_phase_type  ph);
    if (ph == HPM_PH_FIRST) begin
      return w[2*W-1:W];
    end else begin
      return w[W-1:0];
    end
  endfunction : byte_of

  // data pins come from outside the clock domain
  hpm_sync #(
    .WIDTH (W)
  ) u_hpm_sync_pins (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_host_port_data_pins),
    .o_sync  (pins_s)
  );

  // address strobe pin
  hpm_sync #(
    .WIDTH (1)
  ) u_hpm_sync_as (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_host_address_strobe),
    .o_sync  (as_s)
  );

  // data strobe pin, same latency as the data so both line up
  hpm_sync #(
    .WIDTH (1)
  ) u_hpm_sync_strb (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_host_strobe),
    .o_sync  (strb_s)
  );

  // read request pin
  hpm_sync #(
    .WIDTH (1)
  ) u_hpm_sync_rd (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (i_host_read),
    .o_sync  (rd_s)
  );

  // strap synchroniser has no reset: it must track the pin during reset
  always_ff @(posedge i_clock) begin
    strap_m <= i_function_strap_pin;
    strap_s <= strap_m;
  end

  // latch function once
  // the strap is taken at the first edge after release and then frozen,
  // so later strap activity cannot move the pins mid-run
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sel_done <= 1'b0;
      host_fn  <= RST_FUNC_HOST;
    end else if (!sel_done) begin
      sel_done <= 1'b1;
      host_fn  <= strap_s;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hold_en <= RST_HOLD_EN;
    end else if (i_hold_enable_wr) begin
      hold_en <= i_hold_enable_val;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      gpio_dir <= RST_GPIO_DIR;
    end else if (i_gpio_dir_wr && !host_fn) begin
      gpio_dir <= i_gpio_dir;
    end
  end

  // sampled gpio input levels
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      gpio_in <= RST_DATA;
    end else if (!host_fn) begin
      gpio_in <= pins_s;
    end
  end

  // strobe history; idle level of both strobes is low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      strb_d <= 1'b0;
      as_d   <= 1'b0;
    end else begin
      strb_d <= strb_s;
      as_d   <= as_s;
    end
  end

  assign strb_rise = rise_of(strb_s, strb_d);
  assign as_rise   = rise_of(as_s, as_d);
  assign pair_done = host_fn & strb_rise & ~rd_s & (phase == HPM_PH_SECOND);

  // byte phase within a host cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      phase      <= HPM_PH_FIRST;
      first_byte <= RST_DATA;
    end else if (host_fn && strb_rise) begin
      unique case (phase)
        HPM_PH_FIRST: begin
          phase <= HPM_PH_SECOND;
          if (!rd_s) begin
            first_byte <= pins_s;
          end
        end
        HPM_PH_SECOND: begin
          phase <= HPM_PH_FIRST;
        end
        default: begin
          phase <= HPM_PH_FIRST;
        end
      endcase
    end
  end

  // address strobe marks the next pair
  // set wins over the clear when both fall in one cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_pend <= 1'b0;
    end else if (host_fn && as_rise) begin
      addr_pend <= 1'b1;
    end else if (pair_done) begin
      addr_pend <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      word       <= '0;
      word_valid <= 1'b0;
      addr_reg   <= '0;
      addr_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      addr_valid <= 1'b0;
      if (pair_done && addr_pend) begin
        addr_reg   <= {first_byte, pins_s};
        addr_valid <= 1'b1;
      end else if (pair_done) begin
        word       <= {first_byte, pins_s};
        word_valid <= 1'b1;
      end
    end
  end

  // holders keep the last level
  // without holders a floating pin is shown at the reset level
  assign keep_level = hold_en ? pin_out : RST_DATA;

  // host lines driven only on read
  always_comb begin
    next_pin_oe_n = '1;
    next_pin_out  = keep_level;
    if (!sel_done) begin
      next_pin_oe_n = '1;
    end else if (!host_fn) begin
      next_pin_oe_n = ~gpio_dir;
      next_pin_out  = (i_parallel_gpio_out & gpio_dir) | (keep_level & ~gpio_dir);
    end else if (rd_s) begin
      next_pin_oe_n = '0;
      next_pin_out  = byte_of(i_host_read_word, phase);
    end
  end

  // pin drivers registered so outputs leave flip-flops
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_out  <= RST_DATA;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // outputs straight from flip-flops
  assign o_host_port_data_pins   = pin_out;
  assign o_host_port_data_oe_n   = pin_oe_n;
  assign o_hold_enable           = hold_en;
  assign o_host_mode             = host_fn;
  assign o_parallel_gpio_bits    = gpio_in;
  assign o_host_word             = word;
  assign o_host_word_valid       = word_valid;
  assign o_host_address_register = addr_reg;
  assign o_host_address_valid    = addr_valid;
endmodule : hpm_mux

// [verilog/hpm_pkg.sv]
// Overview of operation
// - strap low gives gpio, high gives host
// - function fixed when reset is released
// - holders keep last driven level when floating
// - holders on at reset, software toggles them
// - gpio bits are inputs after reset
// - host lines inputs until host read
// - strap high selects multiplexed host mode
// - two byte transfers form one access
package hpm_pkg;
  localparam int          DATA_WIDTH     = 8;
  localparam logic        RST_HOLD_EN    = 1'b1;
  localparam logic        RST_FUNC_HOST  = 1'b0;
  localparam logic [7:0]  RST_GPIO_DIR   = 8'h00;
  localparam logic [7:0]  RST_DATA       = 8'h00;
  localparam int          SYNC_STAGES    = 2;

  // byte phase of a host cycle, gray along the path
  typedef enum logic [1:0] {
    HPM_PH_FIRST  = 2'b00,
    HPM_PH_SECOND = 2'b01
  } hpm_phase_type;
endpackage : hpm_pkg

// [verilog/hpm_sync.sv]
`timescale 1ns/10ps
// two-stage synchroniser for pin inputs
module hpm_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : hpm_sync

// [verification/hpm_mux_asserts.sv]
`timescale 1ns/10ps
module hpm_mux_asserts(input wire logic i_clock,input wire logic i_rst,
input wire logic o_host_mode,input wire logic o_hold_enable,input wire logic [7:0] o_host_port_data_oe_n,
input wire logic o_host_word_valid,input wire logic [7:0] o_host_port_data_pins);
default clocking @(posedge i_clock); endclocking
default disable iff (i_rst);
a_mode_held: assert property(!$past(i_rst)&&!$past(i_rst,2)|->$stable(o_host_mode)) else $error("mode moved");
a_word_pulse: assert property(o_host_word_valid|=>!o_host_word_valid) else $error("word valid too long");
a_gpio_no_word: assert property(!o_host_mode|->!o_host_word_valid) else $error("word in gpio mode");
a_holder_keep: assert property(&o_host_port_data_oe_n&&$past(o_hold_enable)|->$stable(o_host_port_data_pins)) else $error("holder lost level");
a_holder_on: assert property($fell(i_rst)|->o_hold_enable) else $error("holders off");
a_pins_float: assert property($fell(i_rst)|->&o_host_port_data_oe_n) else $error("pins driven");
endmodule:hpm_mux_asserts

// [verification/hpm_host_model.sv]
`timescale 1ns/10ps
module hpm_host_model(input wire logic i_clock,output logic [7:0] o_data,output logic o_strobe);
initial begin o_strobe=0; o_data=8'h00; end
// two bytes as a pair, then the data lines are driven with the inverse of the last byte
task automatic cycle(input logic [15:0] w);
for(int i=1;i>=0;i--) begin
o_strobe=1; o_data=w[i*8+:8]; @(posedge i_clock); #5;
o_strobe=0; @(posedge i_clock); #5;
end
o_data=~o_data;
endtask:cycle
endmodule:hpm_host_model

// [verification/hpm_mux_tb.sv]
`timescale 1ns/10ps
module hpm_mux_tb;
logic i_clock=0,i_rst=1,sp=0,hw=0; logic [15:0] w,rw=0,q[$]; int mismatches=0,cmp_count=0;
wire [7:0] d,n; wire st,v,m,h,av; wire [15:0] ar; logic as=0;
initial forever #25 i_clock=~i_clock;
hpm_host_model u_hpm_host_model(.i_clock,.o_data(d),.o_strobe(st));
hpm_mux u_hpm_mux(.i_clock,.i_rst,.i_function_strap_pin(sp),.i_host_port_data_pins(d),
.o_host_port_data_pins(),.o_host_port_data_oe_n(n),.i_hold_enable_wr(hw),.i_hold_enable_val(1'b0),
.o_hold_enable(h),.o_host_mode(m),.i_gpio_dir_wr(1'b0),.i_gpio_dir(8'h00),.i_parallel_gpio_out(d),
.o_parallel_gpio_bits(),.i_host_address_strobe(as),.i_host_strobe(st),.i_host_read(1'b0),
.i_host_read_word(rw),.o_host_word(w),.o_host_word_valid(v),.o_host_address_register(ar),
.o_host_address_valid(av));
task automatic cmp(input logic [15:0] a,e); cmp_count++;
if(a!==e) begin mismatches++; $display("mismatch %0t %h %h",$time,a,e); end endtask:cmp
task automatic stop_test; if(mismatches==0&&cmp_count>0) $display("Test passed");
else $display("Test failed"); $finish; endtask:stop_test
// oldest note against each assembled word
always @(posedge i_clock) if(v===1'b1) begin if(q.size()) cmp(w,q.pop_front()); else mismatches++; end
task automatic rst(input logic s); sp=s; i_rst=1; repeat(4) @(posedge i_clock); #5 i_rst=0;
repeat(3) @(posedge i_clock); #5 sp=~s; endtask:rst
initial begin
void'($urandom(11)); rst(0);
cmp(m,16'h0000);
rst(1); cmp(m,16'h0001);
cmp({h,n},16'h01FF);
for(int k=0;k<4;k++) begin rw=$urandom; q.push_back(rw); u_hpm_host_model.cycle(rw); end
hw=1; for(int k=0;k<50&&q.size();k++) @(posedge i_clock); #5 hw=0;
if(q.size()) mismatches++;
cmp({15'h0000,h},16'h0000);
as=1; repeat(4) @(posedge i_clock); #5 as=0; rw=$urandom; u_hpm_host_model.cycle(rw);
for(int k=0;k<20&&av!==1'b1;k++) @(posedge i_clock);
if(av!==1'b1) mismatches++;
cmp(ar,rw);
cmp(m,16'h0001);
stop_test;
end
endmodule:hpm_mux_tb
bind hpm_mux hpm_mux_asserts u_hpm_mux_asserts(.i_clock,.i_rst,.o_host_mode,.o_hold_enable,
.o_host_port_data_oe_n,.o_host_word_valid,.o_host_port_data_pins);
